// File: inc/sald_pkg.sv
// package for the strap address and led driver
package sald_pkg;

  // ==========================================================
  // widths
  localparam int unsigned NUM_PINS = 5;
  localparam int unsigned STRETCH_W = 24;

  // ==========================================================
  // pin positions inside the dual-use pin vector
  localparam int unsigned PIN_ACTIVITY = 0;
  localparam int unsigned PIN_COLLISION = 1;
  localparam int unsigned PIN_LINK = 2;
  localparam int unsigned PIN_TRANSMIT = 3;
  localparam int unsigned PIN_RECEIVE = 4;

  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned REF_MHZ = 25;
  localparam int unsigned REF_DIV = CLK_MHZ / REF_MHZ;
  localparam int unsigned COL_STRETCH_MS = 70;
  localparam int unsigned COL_STRETCH_TICKS = COL_STRETCH_MS * 1000 * REF_MHZ;

  // ==========================================================
  // reset values
  localparam logic [NUM_PINS-1:0] ADDR_RST = 5'h00;
  localparam logic [STRETCH_W-1:0] STRETCH_ZERO = 24'h000000;
  localparam logic [2:0] DIV_ZERO = 3'h0;

  // ==========================================================
  // types
  typedef enum logic [0:0] {
    SALD_SAMPLE,
    SALD_DRIVE
  } sald_mode_e;

  typedef struct packed {
    logic rx_active;
    logic tx_active;
    logic collision;
    logic link_up;
    logic speed_100;
  } sald_status_s;

  typedef struct packed {
    logic [NUM_PINS-1:0] o;
    logic [NUM_PINS-1:0] oe;
  } sald_pin_drv_s;

endpackage

// File: verilog/sald_sync2.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
`default_nettype none

module sald_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule // sald_sync2

`default_nettype wire

// File: verilog/sald_top.sv
// dual-use strap address and status led pin driver
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// RULE1: during hardware reset pins are inputs; level captured at reset release
// RULE2: after capture every dual-use pin becomes an output driving status
// RULE3: software reset neither re-samples pins nor changes their direction
// RULE4: asserted output level is the inverse of the captured strap level
// RULE5: captured low gives address bit 0, captured high gives bit 1
// RULE6: five pins supply station address bits 0 to 4, one each
// RULE7: address bit 0 pin shows receive or transmit activity
// RULE8: address bit 1 pin shows collision, stretched about 70 ms
// RULE9: bits 2, 3, 4 pins show link, transmit and receive
// RULE10: speed output high at 100 Mb/s, low at 10 Mb/s
// RULE11: system reset is active low; low holds hardware reset
// RULE12: timing, collision stretch included, derives from 25 MHz reference
// RULE13: link indicator asserted with valid link, deasserted without
// RULE14: receive led follows rx activity; transmit led off when idle
// RULE15: captured address held unchanged until next hardware reset
module sald_top
  import sald_pkg::*;
#(
  parameter int unsigned STRETCH_TICKS = sald_pkg::COL_STRETCH_TICKS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // software reset request from management logic
  input wire logic i_soft_reset,
  // link status from the phy core
  input wire sald_pkg::sald_status_s i_status,
  // dual-use pins
  input wire logic [sald_pkg::NUM_PINS-1:0] i_pin,
  output logic [sald_pkg::NUM_PINS-1:0] o_pin,
  output logic [sald_pkg::NUM_PINS-1:0] o_pin_oe,
  // captured address and speed indication
  output logic [sald_pkg::NUM_PINS-1:0] o_station_address,
  output logic o_speed_100
);

  import sald_pkg::*;

  // ==========================================================
  // pin synchroniser
  logic [NUM_PINS-1:0] pin_sync;

  sald_sync2 #(
    .W(NUM_PINS)
  ) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_pin),
    .o_q(pin_sync)
  );

  // ==========================================================
  // strap capture at third edge after release
  sald_mode_e mode_q, mode_d;
  logic [NUM_PINS-1:0] addr_q, addr_d;
  logic [1:0] settle_q, settle_d;

  always_comb
  begin
    mode_d = mode_q;
    addr_d = addr_q;
    settle_d = settle_q;
    unique case (mode_q)
      SALD_SAMPLE:
      begin
        // wait for synchroniser to carry post-reset levels
        if (settle_q != 2'h2)
          settle_d = settle_q + 2'h1;
        else
        begin
          addr_d = pin_sync; // RULE1 RULE5 RULE6
          mode_d = SALD_DRIVE; // RULE2
        end
      end
      SALD_DRIVE:
      begin
        // soft reset leaves mode and address alone
        mode_d = SALD_DRIVE; // RULE3 RULE15
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn) // RULE11
    begin
      mode_q <= SALD_SAMPLE;
      addr_q <= ADDR_RST;
      settle_q <= 2'h0;
    end
    else
    begin
      mode_q <= mode_d;
      addr_q <= addr_d;
      settle_q <= settle_d;
    end
  end

  // ==========================================================
  // 25 MHz reference tick and collision stretch
  logic [2:0] div_q, div_d;
  logic ref_tick;
  logic [STRETCH_W-1:0] col_q, col_d;

  assign ref_tick = (div_q == 3'(REF_DIV - 1));

  always_comb
  begin
    div_d = ref_tick ? DIV_ZERO : div_q + 3'h1; // RULE12
    col_d = col_q;
    if (i_status.collision)
      col_d = STRETCH_W'(STRETCH_TICKS); // RULE8
    else if (ref_tick && col_q != STRETCH_ZERO)
      col_d = col_q - STRETCH_W'(1); // RULE12
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      div_q <= DIV_ZERO;
      col_q <= STRETCH_ZERO;
    end
    else
    begin
      div_q <= div_d;
      col_q <= col_d;
    end
  end

  // ==========================================================
  // led indications and pin drive
  logic [NUM_PINS-1:0] ind;
  sald_pin_drv_s drv_q, drv_d;
  logic spd_q, spd_d;

  always_comb
  begin
    ind = '0;
    ind[PIN_ACTIVITY] = i_status.rx_active | i_status.tx_active; // RULE7
    ind[PIN_COLLISION] = (col_q != STRETCH_ZERO); // RULE8
    ind[PIN_LINK] = i_status.link_up; // RULE9 RULE13
    ind[PIN_TRANSMIT] = i_status.tx_active; // RULE9 RULE14
    ind[PIN_RECEIVE] = i_status.rx_active; // RULE9 RULE14
    drv_d.oe = '0;
    drv_d.o = '0;
    if (mode_d == SALD_DRIVE)
    begin
      drv_d.oe = '1; // RULE2 RULE3
      // idle level equals the strap, asserted level is its inverse
      drv_d.o = ind ^ addr_d; // RULE4
    end
    spd_d = i_status.speed_100; // RULE10
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      drv_q <= '0;
      spd_q <= 1'b0;
    end
    else
    begin
      drv_q <= drv_d;
      spd_q <= spd_d;
    end
  end

  assign o_pin = drv_q.o;
  assign o_pin_oe = drv_q.oe;
  assign o_station_address = addr_q;
  assign o_speed_100 = spd_q;

  // ==========================================================
  // checks
  sequence s_captured;
    mode_q == SALD_SAMPLE ##1 mode_q == SALD_DRIVE;
  endsequence

  a_addr_capture: assert property ( // RULE1
    @(posedge i_clk) disable iff (!i_rstn)
    s_captured |-> o_station_address == $past(pin_sync))
    else $error("address not captured from pins");

  a_pins_drive: assert property ( // RULE2
    @(posedge i_clk) disable iff (!i_rstn)
    mode_q == SALD_DRIVE |-> o_pin_oe == '1)
    else $error("pins not driven after capture");

  a_soft_hold: assert property ( // RULE3
    @(posedge i_clk) disable iff (!i_rstn)
    (mode_q == SALD_DRIVE && i_soft_reset) |=> mode_q == SALD_DRIVE
      && o_pin_oe == '1 && $stable(o_station_address))
    else $error("soft reset disturbed pins");

  a_addr_stable: assert property ( // RULE15
    @(posedge i_clk) disable iff (!i_rstn)
    mode_q == SALD_DRIVE |=> $stable(o_station_address))
    else $error("address changed after capture");

  a_led_invert: assert property ( // RULE4
    @(posedge i_clk) disable iff (!i_rstn)
    (mode_q == SALD_DRIVE && $past(mode_q) == SALD_DRIVE) |->
      o_pin == ($past(ind) ^ o_station_address))
    else $error("led polarity wrong");

  a_activity_or: assert property ( // RULE7
    @(posedge i_clk) disable iff (!i_rstn)
    (mode_q == SALD_DRIVE && (i_status.rx_active || i_status.tx_active))
      |=> o_pin[PIN_ACTIVITY] == ~o_station_address[PIN_ACTIVITY])
    else $error("activity led not asserted");

  a_col_stretch: assert property ( // RULE8
    @(posedge i_clk) disable iff (!i_rstn)
    i_status.collision |=> col_q == STRETCH_W'(STRETCH_TICKS))
    else $error("collision stretch not loaded");

  a_link_led: assert property ( // RULE13
    @(posedge i_clk) disable iff (!i_rstn)
    (mode_q == SALD_DRIVE && !i_status.link_up)
      |=> o_pin[PIN_LINK] == o_station_address[PIN_LINK])
    else $error("link led asserted without link");

  a_speed_out: assert property ( // RULE10
    @(posedge i_clk) disable iff (!i_rstn)
    ##1 o_speed_100 == $past(i_status.speed_100))
    else $error("speed indication wrong");

  a_ref_tick: assert property ( // RULE12
    @(posedge i_clk) disable iff (!i_rstn)
    ref_tick |=> !ref_tick [*4] ##1 ref_tick)
    else $error("reference tick period wrong");

endmodule // sald_top

`default_nettype wire

// File: testbench/sald_board.sv
// board model: strap resistors and status leds on the dual-use pins
`timescale 1ns/1ns
`default_nettype none

module sald_board
  import sald_pkg::*;
(
  // strap setting and pin drive
  input wire logic [sald_pkg::NUM_PINS-1:0] i_strap,
  input wire logic [sald_pkg::NUM_PINS-1:0] i_o,
  input wire logic [sald_pkg::NUM_PINS-1:0] i_oe,
  // pin level and lit leds
  output logic [sald_pkg::NUM_PINS-1:0] o_pin,
  output logic [sald_pkg::NUM_PINS-1:0] o_led_on
);
  // undriven pin settles to its strap resistor level
  assign o_pin = (i_oe & i_o) | (~i_oe & i_strap);
  // led lights only when driven against its strap
  assign o_led_on = i_oe & (i_o ^ i_strap);
endmodule // sald_board

`default_nettype wire

// File: testbench/strap_address_led_driver_tb.sv
// self-checking bench for the strap address and led driver
`timescale 1ns/1ns
`default_nettype none

module strap_address_led_driver_tb;
  import sald_pkg::*;
  localparam int unsigned TICKS = 20;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_soft_reset = 1'b0;
  sald_status_s i_status = 5'h00;
  logic [4:0] strap = 5'h00;
  logic [4:0] pin;
  logic [4:0] o_pin;
  logic [4:0] o_pin_oe;
  logic [4:0] addr;
  logic [4:0] led;
  logic o_speed_100;
  int err_count = 0;
  int compares = 0;

  always #4 i_clk = ~i_clk;

  sald_top #(.STRETCH_TICKS(TICKS)) dut (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_soft_reset(i_soft_reset),
    .i_status(i_status),
    .i_pin(pin),
    .o_pin(o_pin),
    .o_pin_oe(o_pin_oe),
    .o_station_address(addr),
    .o_speed_100(o_speed_100)
  );

  sald_board board (
    .i_strap(strap),
    .i_o(o_pin),
    .i_oe(o_pin_oe),
    .o_pin(pin),
    .o_led_on(led)
  );

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [4:0] exp,
    input logic [4:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic give_verdict();
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic hw_reset(input logic [4:0] s);
    tick(1);
    i_rstn = 1'b0;
    strap = s;
    i_status = 5'h00;
    tick(10);
    chk("oe in reset", 5'h00, o_pin_oe);
    i_rstn = 1'b1;
    tick(2);
    chk("oe in capture", 5'h00, o_pin_oe);
    tick(1);
    chk("oe after capture", 5'h1f, o_pin_oe);
    chk("station address", s, addr);
    chk("leds idle", 5'h00, led);
  endtask

  task automatic indications();
    logic [4:0] exp;
    for (int k = 0; k < 16; k++)
    begin
      i_status = {k[0], k[1], 1'b0, k[2], k[3]};
      exp = {k[0], k[1], k[2], 1'b0, k[0] | k[1]};
      tick(1);
      chk("leds", exp, led);
      chk("pins", strap ^ exp, pin);
      chk("speed", {4'h0, k[3]}, {4'h0, o_speed_100});
    end
    i_status = 5'h00;
    tick(1);
  endtask

  task automatic collision();
    i_status = 5'h04;
    tick(1);
    i_status = 5'h00;
    // stretch counter loads first, led follows one cycle later
    tick(1);
    chk("collision on", 5'h02, led);
    tick(TICKS * 5 - 15);
    chk("collision held", 5'h02, led);
    tick(30);
    chk("collision off", 5'h00, led);
  endtask

  task automatic soft_reset(input logic [4:0] s);
    i_soft_reset = 1'b1;
    strap = ~s;
    tick(5);
    chk("oe in soft reset", 5'h1f, o_pin_oe);
    i_soft_reset = 1'b0;
    tick(3);
    chk("address kept", s, addr);
    strap = s;
    tick(1);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    hw_reset(5'h0d);
    indications();
    collision();
    soft_reset(5'h0d);
    hw_reset(5'h12);
    indications();
    collision();
    give_verdict();
  end

  initial
  begin
    #40000;
    err_count++;
    give_verdict();
  end
endmodule // strap_address_led_driver_tb

`default_nettype wire
